/* File: core/led_sink_config_regs.sv */
// Register bank for four LED current sink channels, APB slave.
// Assumes an APB master on clk and a sequencer on the same clock.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Bit 18 enables the shared signal reference for analog blocks.
// - Bits 11 down to 8 switch sink channels four to one on.
// - Bits 7:6 pick channel four range: 25, 50, 100 mA; 3 unused.
// - Channels three, two, one use bits 5:4, 3:2, 1:0 alike.
// - Sinks follow manual switches or the sequencer, per selected mode.
// - Bit 26 of manual register: zero sequencer, one manual control.
// - Current is (code + 1) times range over 256; code zero none.
module led_sink_config_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [led_sink_pkg::addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer switch requests
  input wire logic [3:0] seq_sink_on,
  // Analog controls
  output logic sigref_on,
  output logic [3:0] sink_drive,
  output logic [3:0][1:0] sink_full_scale,
  output logic [3:0][16:0] sink_current_ua
);
  import led_sink_pkg::*;

  typedef struct packed {
    logic sigref;
    logic [3:0] sink_on;
    logic [7:0] full_scale;
    logic [31:0] level_code;
    logic manual_mode;
    logic [3:0] manual_sw;
    logic [31:0] rdata;
  } reg_state_type;

  reg_state_type state;
  reg_state_type next_state;
  logic [1:0] rst_pipe;
  logic rst_sync_b;
  logic setup_phase;
  logic access_write;
  logic mapped;

  sink_ctrl_if ctrl ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_sync_b = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Address hit check
  function automatic logic is_mapped(input logic [7:0] addr);
    if (addr == setup_offset)
      is_mapped = 1'b1;
    else if (addr == level_offset)
      is_mapped = 1'b1;
    else if (addr == manual_offset)
      is_mapped = 1'b1;
    else
      is_mapped = 1'b0;
  endfunction : is_mapped

  // Read word of one register, reserved bits zero
  function automatic logic [31:0] read_word(input reg_state_type s,
                                            input logic [7:0] addr);
    logic [31:0] word;
    word = 32'h00000000;
    if (addr == setup_offset)
    begin
      word[sigref_bit] = s.sigref;
      word[sink_on_lsb +: 4] = s.sink_on;
      word[full_scale_lsb +: 8] = s.full_scale;
    end
    else if (addr == level_offset)
      word = s.level_code;
    else if (addr == manual_offset)
    begin
      word[manual_mode_bit] = s.manual_mode;
      word[manual_sw_lsb +: 4] = s.manual_sw;
    end
    read_word = word;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode
  assign setup_phase = psel && !penable;
  assign access_write = psel && penable && pwrite;
  assign mapped = is_mapped(paddr);

  // Register writes and read data capture
  always_comb
  begin
    next_state = state;
    if (setup_phase && !pwrite)
      next_state.rdata = read_word(state, paddr);
    if (access_write && paddr == setup_offset)
    begin
      next_state.sigref = pwdata[sigref_bit];
      next_state.sink_on = pwdata[sink_on_lsb +: 4];
      next_state.full_scale = pwdata[full_scale_lsb +: 8];
    end
    else if (access_write && paddr == level_offset)
      next_state.level_code = pwdata;
    else if (access_write && paddr == manual_offset)
    begin
      next_state.manual_mode = pwdata[manual_mode_bit];
      next_state.manual_sw = pwdata[manual_sw_lsb +: 4];
    end
  end

  // State register with reset defaults
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state <= '0;
      state.full_scale <= full_scale_reset;
      state.level_code <= level_reset;
    end
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers: no wait states, error on unmapped access
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = state.rdata;

  // Settings to the calculation stage
  assign ctrl.ready_b = rst_sync_b;
  assign ctrl.sigref = state.sigref;
  assign ctrl.sink_on = state.sink_on;
  assign ctrl.full_scale = state.full_scale;
  assign ctrl.level_code = state.level_code;
  assign ctrl.manual_mode = state.manual_mode;
  assign ctrl.manual_sw = state.manual_sw;
  assign ctrl.seq_sw = seq_sink_on;

  sink_drive_calc calc (
    .clk(clk),
    .ctrl(ctrl)
  );

  // Analog outputs
  assign sigref_on = state.sigref;
  assign sink_full_scale = state.full_scale;
  assign sink_drive = ctrl.drive;
  assign sink_current_ua = ctrl.current;

  ////////////////////////////////////////////////////////////////////////////
  default clocking regs_clk @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence setup_write;
    psel && penable && pwrite && paddr == setup_offset;
  endsequence

  sequence manual_write;
    psel && penable && pwrite && paddr == manual_offset;
  endsequence

  sigref_write_a: assert property (setup_write |=>
    sigref_on == $past(pwdata[18]))
    else $error("signal reference bit not stored");

  enable_write_a: assert property (setup_write |=>
    state.sink_on == $past(pwdata[11:8]))
    else $error("sink enables not stored");

  range_four_a: assert property (setup_write |=>
    sink_full_scale[3] == $past(pwdata[7:6]))
    else $error("channel four range not stored");

  range_low_a: assert property (setup_write |=>
    sink_full_scale[2] == $past(pwdata[5:4]) &&
    sink_full_scale[1] == $past(pwdata[3:2]) &&
    sink_full_scale[0] == $past(pwdata[1:0]))
    else $error("channel range fields misplaced");

  mode_write_a: assert property (manual_write |=>
    state.manual_mode == $past(pwdata[26]))
    else $error("mode bit not stored");

  reset_defaults_a: assert property ($rose(rst_sync_b) |->
    state.sink_on == 4'h0 && !sigref_on && sink_full_scale == 8'h55)
    else $error("reset defaults wrong");

  setup_read_a: assert property (psel && !penable && !pwrite &&
    paddr == setup_offset ##1 psel && penable |->
    prdata == {13'h0000, sigref_on, 6'h00, state.sink_on,
    sink_full_scale})
    else $error("setup register read back wrong");

  level_write_a: assert property (psel && penable && pwrite &&
    paddr == level_offset |=> state.level_code == $past(pwdata))
    else $error("level codes not stored");

  unmapped_hold_a: assert property (psel && penable && pwrite && !mapped
    |=> state.sink_on == $past(state.sink_on) &&
    state.sigref == $past(state.sigref))
    else $error("unmapped write changed settings");

  unmapped_read_a: assert property (psel && !penable && !pwrite &&
    !mapped ##1 psel && penable |-> prdata == 32'h00000000)
    else $error("unmapped read returns data");

  unmapped_error_a: assert property (psel && penable &&
    !(paddr inside {8'h00, 8'h04, 8'h20}) |-> pslverr)
    else $error("unmapped access without error");

endmodule : led_sink_config_regs
`default_nettype wire

/* File: core/led_sink_pkg.sv */
// Shared constants for the LED current sink configuration block.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
package led_sink_pkg;

  // Channel count and field widths
  localparam int channels = 4;
  localparam int addr_width = 8;
  localparam int current_width = 17;

  // Register byte offsets
  localparam logic [7:0] setup_offset = 8'h00;
  localparam logic [7:0] level_offset = 8'h04;
  localparam logic [7:0] manual_offset = 8'h20;

  // Field positions
  localparam int sigref_bit = 18;
  localparam int sink_on_lsb = 8;
  localparam int full_scale_lsb = 0;
  localparam int manual_mode_bit = 26;
  localparam int manual_sw_lsb = 19;

  // Reset values
  localparam logic [7:0] full_scale_reset = 8'h55;
  localparam logic [31:0] level_reset = 32'h00000000;

  // Full-scale range codes
  typedef enum logic [1:0] {
    range_25 = 2'b00,
    range_50 = 2'b01,
    range_100 = 2'b10,
    range_bad = 2'b11
  } full_scale_type;

  // Full-scale currents in microamps
  localparam logic [16:0] range_25_ua = 17'h061A8;
  localparam logic [16:0] range_50_ua = 17'h0C350;
  localparam logic [16:0] range_100_ua = 17'h186A0;

endpackage : led_sink_pkg

/* File: core/sink_ctrl_if.sv */
// Carrier between the register bank and the sink calculation stage.
// Assumes both ends share one clock and the synchronised reset.
`timescale 1ns/1ns
`default_nettype none
interface sink_ctrl_if;
  import led_sink_pkg::*;
  logic ready_b;
  logic sigref;
  logic [3:0] sink_on;
  logic [3:0][1:0] full_scale;
  logic [3:0][7:0] level_code;
  logic manual_mode;
  logic [3:0] manual_sw;
  logic [3:0] seq_sw;
  logic [3:0] drive;
  logic [3:0][16:0] current;

  // Register side
  modport cfg (
    output ready_b, sigref, sink_on, full_scale, level_code,
    output manual_mode, manual_sw, seq_sw,
    input drive, current
  );

  // Calculation side
  modport sink (
    input ready_b, sigref, sink_on, full_scale, level_code,
    input manual_mode, manual_sw, seq_sw,
    output drive, current
  );
endinterface : sink_ctrl_if
`default_nettype wire

/* File: core/sink_drive_calc.sv */
// Per-channel drive selection and sink current calculation.
// Assumes settings arrive from the register bank on the same clock.
`timescale 1ns/1ns
`default_nettype none
module sink_drive_calc
(
  // Clock
  input wire logic clk,
  // Settings in, drive out
  sink_ctrl_if.sink ctrl
);
  import led_sink_pkg::*;

  typedef struct packed {
    logic [3:0] drive;
    logic [3:0][16:0] current;
  } calc_state_type;

  calc_state_type state;
  calc_state_type next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Full-scale current of a range code; unused code gives none
  function automatic logic [16:0] full_scale_ua(input logic [1:0] code);
    case (full_scale_type'(code))
      range_25: full_scale_ua = range_25_ua;
      range_50: full_scale_ua = range_50_ua;
      range_100: full_scale_ua = range_100_ua;
      default: full_scale_ua = 17'h00000;
    endcase
  endfunction : full_scale_ua

  // Level current: (code + 1) steps of full scale / 256, none for code 0
  function automatic logic [16:0] level_ua(input logic [7:0] code,
                                           input logic [1:0] range);
    logic [25:0] product;
    product = 26'({1'b0, code} + 9'h001) * 26'(full_scale_ua(range));
    if (code == 8'h00)
      level_ua = 17'h00000;
    else
      level_ua = product[24:8];
  endfunction : level_ua

  ////////////////////////////////////////////////////////////////////////////
  // Next drive and current per channel
  always_comb
  begin
    next_state = state;
    for (int i = 0; i < channels; i++)
    begin
      next_state.drive[i] = ctrl.sigref && ctrl.sink_on[i] &&
        (ctrl.manual_mode ? ctrl.manual_sw[i] : ctrl.seq_sw[i]);
      next_state.current[i] = next_state.drive[i] ?
        level_ua(ctrl.level_code[i], ctrl.full_scale[i]) : 17'h00000;
    end
  end

  // State register
  always_ff @(posedge clk or negedge ctrl.ready_b)
  begin
    if (!ctrl.ready_b)
      state <= '0;
    else
      state <= next_state;
  end

  // Outputs from flip-flops
  assign ctrl.drive = state.drive;
  assign ctrl.current = state.current;

  ////////////////////////////////////////////////////////////////////////////
  default clocking calc_clk @(posedge clk); endclocking
  default disable iff (!ctrl.ready_b);

  sequence manual_ch0;
    ctrl.manual_mode && ctrl.sigref && ctrl.sink_on[0];
  endsequence

  sequence seq_ch0;
    !ctrl.manual_mode && ctrl.sigref && ctrl.sink_on[0];
  endsequence

  manual_drive_a: assert property (manual_ch0 |=>
    ctrl.drive[0] == $past(ctrl.manual_sw[0]))
    else $error("manual drive does not follow switch");

  sequencer_drive_a: assert property (seq_ch0 |=>
    ctrl.drive[0] == $past(ctrl.seq_sw[0]))
    else $error("sequencer drive does not follow sequencer");

  zero_code_a: assert property (ctrl.level_code[1] == 8'h00 |=>
    ctrl.current[1] == 17'h00000)
    else $error("code zero gives current");

  full_code_a: assert property (ctrl.level_code[3] == 8'hFF &&
    ctrl.full_scale[3] == 2'b10 && ctrl.sigref && ctrl.sink_on[3] &&
    ctrl.manual_mode && ctrl.manual_sw[3] |=>
    ctrl.current[3] == 17'h186A0)
    else $error("full code not at full scale");

  sigref_off_a: assert property (!ctrl.sigref |=> ctrl.drive == 4'h0)
    else $error("sink driven without signal reference");

endmodule : sink_drive_calc
`default_nettype wire

/* File: bench/sink_load_model.sv */
// Behavioural load of four analog current sinks.
// Assumes settings arrive level-held from the register bank.
`timescale 1ns/1ns
`default_nettype none
module sink_load_model
(
  // Controls from the block
  input wire logic sigref_on,
  input wire logic [3:0] sink_drive,
  input wire logic [3:0][16:0] sink_current_ua,
  // Current actually drawn per channel
  output logic [3:0][16:0] load_ua
);
  // Undriven or unreferenced sink is high impedance, draws nothing
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      load_ua[i] = (sigref_on && sink_drive[i]) ?
        sink_current_ua[i] : 17'h00000;
    end
  end
endmodule : sink_load_model
`default_nettype wire

/* File: bench/led_sink_config_regs_tb_top.sv */
// Self-checking bench for the LED sink register bank.
// Assumes the APB slave answers with pready and no byte strobes.
`timescale 1ns/1ns
`default_nettype none
module led_sink_config_regs_tb_top;
  import led_sink_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] seq_sink_on = 4'h0;
  logic sigref_on;
  logic [3:0] sink_drive;
  logic [3:0][1:0] sink_full_scale;
  logic [3:0][16:0] sink_current_ua;
  logic [3:0][16:0] load_ua;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int check_count = 0;

  //////////////////////////////////////////////////////////////////////////
  // Design and sink load
  led_sink_config_regs i_led_sink_config_regs (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_sink_on(seq_sink_on), .sigref_on(sigref_on),
    .sink_drive(sink_drive), .sink_full_scale(sink_full_scale),
    .sink_current_ua(sink_current_ua));
  sink_load_model i_sink_load_model (.sigref_on(sigref_on),
    .sink_drive(sink_drive), .sink_current_ua(sink_current_ua),
    .load_ua(load_ua));

  // Clock generator
  initial
  begin
    forever #2 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Word compare
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  // Current compare
  task automatic check_ua(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_ua

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      complete_run();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Read and compare data and error flag
  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp,
    input logic exp_err);
    apb(1'b0, a, 32'h00000000);
    check_word(rd, exp);
    check_word({31'h0, err}, {31'h0, exp_err});
  endtask : read_chk

  // Expected sink current from code and range
  function automatic logic [16:0] exp_ua(input logic [7:0] code,
    input logic [1:0] r);
    logic [25:0] p;
    p = (r == 2'h0) ? 26'(range_25_ua) : (r == 2'h1) ? 26'(range_50_ua)
      : (r == 2'h2) ? 26'(range_100_ua) : 26'h0;
    p = (code == 8'h00) ? 26'h0 : (26'(code) + 26'h1) * p;
    return p[24:8];
  endfunction : exp_ua

  // Let the write reach the sinks, then compare drive and loads
  task automatic drive_chk(input logic [3:0] exp_drv,
    input logic [31:0] lv, input logic [7:0] fs);
    repeat (3) @(posedge clk);
    #1;
    check_word({28'h0, sink_drive}, {28'h0, exp_drv});
    for (int i = 0; i < 4; i++)
      check_ua(load_ua[i], exp_drv[i] ?
        exp_ua(lv[8*i +: 8], fs[2*i +: 2]) : 17'h0);
  endtask : drive_chk

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check_word({24'h0, sink_full_scale}, 32'h00000055);
    check_word({31'h0, sigref_on}, 32'h00000000);
    read_chk(8'h00, 32'h00000055, 1'b0);
    read_chk(8'h04, 32'h00000000, 1'b0);
    read_chk(8'h20, 32'h00000000, 1'b0);
    // Reserved bits dropped, fields land at their positions
    apb(1'b1, 8'h00, 32'hFFFFFF86);
    read_chk(8'h00, 32'h00040F86, 1'b0);
    apb(1'b1, 8'h04, 32'hFF7F0001);
    read_chk(8'h04, 32'hFF7F0001, 1'b0);
    check_word({31'h0, sigref_on}, 32'h00000001);
    check_word({24'h0, sink_full_scale}, 32'h00000086);
    // Manual control, all then two switches
    apb(1'b1, 8'h20, 32'h04780000);
    drive_chk(4'hF, 32'hFF7F0001, 8'h86);
    apb(1'b1, 8'h20, 32'h04280000);
    drive_chk(4'h5, 32'hFF7F0001, 8'h86);
    // Sequencer control ignores manual switches
    seq_sink_on <= 4'hA;
    apb(1'b1, 8'h20, 32'h00780000);
    drive_chk(4'hA, 32'hFF7F0001, 8'h86);
    // Channel enable off, then reference off
    apb(1'b1, 8'h00, 32'h00040786);
    drive_chk(4'h2, 32'hFF7F0001, 8'h86);
    apb(1'b1, 8'h00, 32'h00000F86);
    drive_chk(4'h0, 32'hFF7F0001, 8'h86);
    // Unmapped place refuses and leaves registers alone
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    check_word({31'h0, err}, 32'h00000001);
    read_chk(8'h10, 32'h00000000, 1'b1);
    read_chk(8'h00, 32'h00000F86, 1'b0);
    // Reset in mid-run brings back the defaults
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_word({24'h0, sink_full_scale}, 32'h00000055);
    check_word({28'h0, sink_drive}, 32'h00000000);
    read_chk(8'h00, 32'h00000055, 1'b0);
    read_chk(8'h20, 32'h00000000, 1'b0);
    complete_run();
  end
endmodule : led_sink_config_regs_tb_top
`default_nettype wire
